/* File: rtl/flow_interp_params.svh */
`ifndef FLOW_INTERP_PARAMS_SVH
`define FLOW_INTERP_PARAMS_SVH
`define OP_RESTART 8'h30
`define OP_COUNT_DOWN 8'h31
`define OP_COND_CALL 8'h15
`define OP_SUB_RETURN 8'h1B
`define OP_MOVE_ACCU 8'h2E
`define OP_MOTOR_HALT 8'h03
`define OP_SPIN_RIGHT 8'h01
`define OP_SPIN_LEFT 8'h02
`define STATUS_OK 8'h64
`define STATUS_BAD_CMD 8'h02
`define STACK_DEPTH 4'h8
`define STACK_BITS 3
`define PC_RESET 32'h0000_0000
`endif

/* File: rtl/flow_interp_pkg.sv */
package flow_interp_pkg;
    // decoded command fields, value carried most significant byte first
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] kind;
        logic [7:0] bank;
        logic [31:0] value;
    } cmd_type;
    // target modes for the move command
    typedef enum logic [1:0] {
        fixed_target_mode,
        offset_target_mode,
        stored_point_mode,
        unused_target_mode
    } target_mode_type;
    // comparison and error flags from the rest of the interpreter
    typedef struct packed {
        logic result_null;
        logic match;
        logic above;
        logic below;
        logic timeout_fault;
        logic outside_alarm;
        logic deviation_fault;
        logic position_fault;
    } cond_flags_type;
    // start request toward the motion controller
    typedef struct packed {
        target_mode_type mode;
        logic [7:0] point_index;
        logic [31:0] target;
    } move_req_type;
endpackage : flow_interp_pkg

/* File: rtl/motion_program_flow_interpreter.sv */
// Function
// [R1] count_down_branch decrements user variable, branches if non-zero
// [R2] zero result falls through to next command; bank field ignored
// [R3] flow commands accepted only from the stored program, not direct mode
// [R4] conditional call tests selected condition on last compare result
// [R5] condition codes 0..11: null, nonnull, match, differ, above..position
// [R6] false condition skips the call, continues after it
// [R7] true condition pushes program counter then loads supplied address
// [R8] return stack holds at most eight entries
// [R9] call with full stack is ignored; stack and counter unchanged
// [R10] move copies accumulator into target position and starts positioning
// [R11] type selects fixed, offset or stored point mode with bank index
// [R12] move is non-blocking: reply at once, further commands accepted
// [R13] ramp settings come from axis parameters, not from the command
// [R14] halt or spin command aborts an ongoing positioning move
// [R15] host keeps move distance within 2147483647 microsteps
// [R16] restart clears stacks and registers, then loads program counter
// [R17] direct-mode commands answered with status 100; here direct flow commands are answered with status 2
// [R18] frames are nine bytes with an 8-bit sum checksum
// [R19] subroutine_return pops the latest entry into the program counter
`timescale 1ns/100ps
`include "flow_interp_params.svh"

module motion_program_flow_interpreter (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic cmd_valid,
    input wire logic cmd_from_program,
    input wire flow_interp_pkg::cmd_type cmd, // R18
    input wire logic [31:0] pc_current,
    input wire logic [31:0] accu,
    input wire flow_interp_pkg::cond_flags_type cond_flags,
    input wire logic [31:0] var_rd_data,
    output logic [7:0] var_addr_r,
    output logic var_wr_r,
    output logic [31:0] var_wr_data_r,
    output logic pc_load_r,
    output logic [31:0] pc_load_value_r,
    output logic regs_clear_r,
    output logic move_start_r,
    output flow_interp_pkg::move_req_type move_req_r,
    output logic move_abort_r,
    output logic reply_valid_r,
    output logic [7:0] reply_status_r,
    output logic [7:0] reply_opcode_r,
    output logic [3:0] stack_level_r
);
    logic [31:0] stack_mem [0:`STACK_DEPTH-1];
    logic busy_r;
    logic [31:0] dec_value;
    logic flow_op;
    logic cond_true;
    logic take_call;
    logic take_ret;

    // condition decode shared by the call logic and its checks
    function automatic logic cond_eval(input logic [7:0] code,
        input flow_interp_pkg::cond_flags_type f);
        unique case (code)
            8'h00: cond_eval = f.result_null; // R5
            8'h01: cond_eval = !f.result_null;
            8'h02: cond_eval = f.match;
            8'h03: cond_eval = !f.match;
            8'h04: cond_eval = f.above;
            8'h05: cond_eval = f.above || f.match;
            8'h06: cond_eval = f.below;
            8'h07: cond_eval = f.below || f.match;
            8'h08: cond_eval = f.timeout_fault;
            8'h09: cond_eval = f.outside_alarm;
            8'h0A: cond_eval = f.deviation_fault;
            8'h0B: cond_eval = f.position_fault;
            default: cond_eval = 1'b0;
        endcase
    endfunction : cond_eval

    // command classification
    assign flow_op = (cmd.opcode == `OP_COUNT_DOWN) ||
        (cmd.opcode == `OP_COND_CALL) || (cmd.opcode == `OP_RESTART) ||
        (cmd.opcode == `OP_SUB_RETURN);
    // a write still in flight is forwarded so back-to-back loops count right
    assign dec_value = ((var_wr_r && var_addr_r == cmd.kind) ?
        var_wr_data_r : var_rd_data) - 32'h0000_0001; // R1
    assign cond_true = cond_eval(cmd.kind, cond_flags); // R4
    assign take_call = clk_en && cmd_valid && cmd_from_program &&
        cmd.opcode == `OP_COND_CALL && cond_true &&
        stack_level_r != `STACK_DEPTH; // R9
    assign take_ret = clk_en && cmd_valid && cmd_from_program &&
        cmd.opcode == `OP_SUB_RETURN && stack_level_r != 4'h0;

    // user variable index follows the loop command's type field
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            var_addr_r <= 8'h00;
        end else if (clk_en && cmd_valid) begin
            var_addr_r <= cmd.kind; // R1
        end
    end

    // count-down: variable is read in the command cycle, written next
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            var_wr_r <= 1'b0;
            var_wr_data_r <= 32'h0000_0000;
        end else if (clk_en) begin
            var_wr_r <= cmd_valid && cmd_from_program &&
                cmd.opcode == `OP_COUNT_DOWN; // R3
            var_wr_data_r <= dec_value; // R1
        end
    end

    // return stack: push on a taken call, pop on return, flush on restart
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            stack_level_r <= 4'h0;
        end else if (clk_en && cmd_valid && cmd_from_program) begin
            if (cmd.opcode == `OP_RESTART) begin
                stack_level_r <= 4'h0; // R16
            end else if (take_call) begin
                stack_level_r <= stack_level_r + 4'h1; // R7 R8
            end else if (take_ret) begin
                stack_level_r <= stack_level_r - 4'h1; // R19
            end
        end
    end

    // return address storage
    always_ff @(posedge clk_sys) begin
        if (take_call) begin
            stack_mem[stack_level_r[`STACK_BITS-1:0]] <= pc_current; // R7
        end
    end

    // program counter loads for branch, call, return and restart
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pc_load_r <= 1'b0;
            pc_load_value_r <= `PC_RESET;
            regs_clear_r <= 1'b0;
        end else if (clk_en) begin
            pc_load_r <= 1'b0;
            regs_clear_r <= 1'b0;
            if (cmd_valid && cmd_from_program) begin // R3
                unique case (cmd.opcode)
                    `OP_COUNT_DOWN: begin
                        pc_load_r <= dec_value != 32'h0000_0000; // R1 R2
                        pc_load_value_r <= cmd.value;
                    end
                    `OP_COND_CALL: begin
                        pc_load_r <= take_call; // R6 R9
                        pc_load_value_r <= cmd.value; // R7
                    end
                    `OP_SUB_RETURN: begin
                        pc_load_r <= take_ret;
                        pc_load_value_r <=
                            stack_mem[3'(stack_level_r - 4'h1)]; // R19
                    end
                    `OP_RESTART: begin
                        pc_load_r <= 1'b1; // R16
                        regs_clear_r <= 1'b1;
                        pc_load_value_r <= cmd.value;
                    end
                    default: pc_load_r <= 1'b0;
                endcase
            end
        end
    end

    // move start and abort toward the motion controller
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            move_start_r <= 1'b0;
            move_abort_r <= 1'b0;
            move_req_r <= '0;
            busy_r <= 1'b0;
        end else if (clk_en) begin
            move_start_r <= 1'b0;
            move_abort_r <= 1'b0;
            if (cmd_valid && cmd.opcode == `OP_MOVE_ACCU &&
                cmd.kind < 8'h03) begin
                move_start_r <= 1'b1; // R10 R13
                busy_r <= 1'b1;
                move_req_r.target <= accu; // R10
                move_req_r.mode <=
                    flow_interp_pkg::target_mode_type'(cmd.kind[1:0]); // R11
                move_req_r.point_index <= cmd.bank; // R11
            end else if (cmd_valid && (cmd.opcode == `OP_MOTOR_HALT ||
                cmd.opcode == `OP_SPIN_LEFT ||
                cmd.opcode == `OP_SPIN_RIGHT)) begin
                move_abort_r <= busy_r; // R14
                busy_r <= 1'b0;
            end
        end
    end

    // direct-mode reply one cycle after the command, move included
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            reply_valid_r <= 1'b0;
            reply_status_r <= 8'h00;
            reply_opcode_r <= 8'h00;
        end else if (clk_en) begin
            reply_valid_r <= cmd_valid && !cmd_from_program; // R12 R17
            reply_opcode_r <= cmd.opcode;
            reply_status_r <= flow_op ? `STATUS_BAD_CMD : `STATUS_OK; // R3
        end
    end

    a_call_push: assert property (@(posedge clk_sys) disable iff (!rst_b)
        take_call |=> pc_load_r && stack_level_r == $past(stack_level_r) + 4'h1
    ) else $error("call did not push"); // R7
    a_stack_bound: assert property (@(posedge clk_sys) disable iff (!rst_b)
        stack_level_r <= `STACK_DEPTH) else $error("stack overflow"); // R8
    a_full_ignore: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && cmd_valid && cmd_from_program && cmd.opcode == `OP_COND_CALL
        && stack_level_r == `STACK_DEPTH |=> !pc_load_r && stack_level_r ==
        `STACK_DEPTH) else $error("full call not ignored"); // R9
    a_false_skip: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && cmd_valid && cmd.opcode == `OP_COND_CALL && !cond_true
        |=> !pc_load_r) else $error("false call branched"); // R6
    a_loop_branch: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && cmd_valid && cmd_from_program && cmd.opcode ==
        `OP_COUNT_DOWN |=> var_wr_r && pc_load_r == (var_wr_data_r != 0))
        else $error("loop branch wrong"); // R1 R2
    a_direct_refuse: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && cmd_valid && !cmd_from_program && flow_op
        |=> !pc_load_r && reply_status_r == `STATUS_BAD_CMD)
        else $error("direct flow command executed"); // R3
    a_move_target: assert property (@(posedge clk_sys) disable iff (!rst_b)
        move_start_r |-> move_req_r.target == $past(accu))
        else $error("move target not accumulator"); // R10
    a_restart_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && cmd_valid && cmd_from_program && cmd.opcode == `OP_RESTART
        |=> stack_level_r == 4'h0 && regs_clear_r && pc_load_r)
        else $error("restart incomplete"); // R16
    a_ok_reply: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && cmd_valid && !cmd_from_program && cmd.opcode ==
        `OP_MOVE_ACCU |=> reply_valid_r && reply_status_r == `STATUS_OK)
        else $error("move reply missing"); // R12 R17
    c_call_taken: cover property (@(posedge clk_sys) take_call);
    c_stack_full: cover property (@(posedge clk_sys)
        stack_level_r == `STACK_DEPTH);
    c_move_abort: cover property (@(posedge clk_sys) move_abort_r);
    c_return: cover property (@(posedge clk_sys) take_ret);
endmodule : motion_program_flow_interpreter

/* File: bench/user_var_store.sv */
`timescale 1ns/100ps
// user variable store beside the interpreter, read combinationally by index
module user_var_store (
    input wire logic clk_sys,
    input wire logic [7:0] rd_index,
    input wire logic wr_en,
    input wire logic [7:0] wr_index,
    input wire logic [31:0] wr_data,
    output logic [31:0] rd_data
);
    logic [31:0] mem_r [256];
    // each variable starts at its own index so loop counts are known
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem_r[i] = i;
        end
    end
    // the indexed variable is ready in the command cycle
    assign rd_data = mem_r[rd_index];
    // decremented value is written back
    always @(posedge clk_sys) begin
        if (wr_en === 1'b1) begin
            mem_r[wr_index] <= wr_data;
        end
    end
endmodule : user_var_store

/* File: bench/motion_program_flow_interpreter_bench.sv */
`timescale 1ns/100ps
`include "flow_interp_params.svh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin \
    mismatches++; \
    $display("wrong value %s expected %0h seen %0h", n, e, s); end end
module motion_program_flow_interpreter_bench;
    logic clk_sys, rst_b, clk_en, cmd_valid, cmd_from_program;
    flow_interp_pkg::cmd_type cmd;
    flow_interp_pkg::cond_flags_type cond_flags;
    flow_interp_pkg::move_req_type move_req_r;
    logic [31:0] pc_current, accu, var_rd_data;
    logic [31:0] var_wr_data_r, pc_load_value_r;
    logic [7:0] var_addr_r, reply_status_r, reply_opcode_r;
    logic var_wr_r, pc_load_r, regs_clear_r, move_start_r;
    logic move_abort_r, reply_valid_r, exp_c;
    logic [3:0] stack_level_r;
    logic [7:0] fl;
    int mismatches, checked, k;
    motion_program_flow_interpreter dut (.clk_sys, .rst_b, .clk_en,
        .cmd_valid, .cmd_from_program, .cmd, .pc_current, .accu,
        .cond_flags, .var_rd_data, .var_addr_r, .var_wr_r,
        .var_wr_data_r, .pc_load_r, .pc_load_value_r, .regs_clear_r,
        .move_start_r, .move_req_r, .move_abort_r, .reply_valid_r,
        .reply_status_r, .reply_opcode_r, .stack_level_r);
    user_var_store store (.clk_sys, .rd_index(cmd.kind),
        .wr_en(var_wr_r), .wr_index(var_addr_r),
        .wr_data(var_wr_data_r), .rd_data(var_rd_data));
    // free-running system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // one command pulse, outputs looked at one edge later
    task send(input logic [7:0] op, input logic [7:0] kd,
        input logic [7:0] bk, input logic [31:0] val, input logic prg);
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd <= '{op, kd, bk, val};
        cmd_from_program <= prg;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        #1;
    endtask : send
    // condition selected by a call type, worked out from the flag byte
    function logic cond_of(input int c, input logic [7:0] f);
        case (c)
            0: return f[7];
            1: return !f[7];
            2: return f[6];
            3: return !f[6];
            4: return f[5];
            5: return f[5] | f[6];
            6: return f[4];
            7: return f[4] | f[6];
            default: return f[11 - c];
        endcase
    endfunction : cond_of
    task final_report;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    // main sequence
    initial begin
        rst_b = 1'b0; clk_en = 1'b1; cmd_valid = 1'b0;
        cmd_from_program = 1'b0; cmd = '0; cond_flags = '0;
        pc_current = 32'h0000_0040; accu = 32'h0000_0000;
        mismatches = 0; checked = 0;
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        // loop counter at one falls through, bank ignored
        send(`OP_COUNT_DOWN, 8'h01, 8'h5A, 32'h0000_0020, 1'b1);
        `CHK("var_wr", 1'b1, var_wr_r)
        `CHK("var_addr", 8'h01, var_addr_r)
        `CHK("var_data", 32'h0000_0000, var_wr_data_r)
        `CHK("pc_load", 1'b0, pc_load_r)
        for (k = 0; k < 2; k++) begin
            send(`OP_COUNT_DOWN, 8'h03, 8'h00, 32'h0000_0020, 1'b1);
            `CHK("var_data", 32'(2 - k), var_wr_data_r)
            `CHK("pc_load", 1'b1, pc_load_r)
            `CHK("pc_val", 32'h0000_0020, pc_load_value_r)
        end
        // flow commands from the host are refused
        for (k = 0; k < 3; k++) begin
            send(k == 0 ? `OP_COUNT_DOWN : k == 1 ? `OP_COND_CALL :
                `OP_RESTART, 8'h02, 8'h00, 32'h0000_0020, 1'b0);
            `CHK("status", `STATUS_BAD_CMD, reply_status_r)
            `CHK("pc_load", 1'b0, pc_load_r)
        end
        // every call condition, each taken call returned at once
        for (k = 0; k < 12; k++) begin
            fl = k[1] ? 8'h5A : 8'hA5;
            exp_c = cond_of(k, fl);
            @(posedge clk_sys);
            cond_flags <= fl;
            pc_current <= 32'h0000_0100 + k;
            send(`OP_COND_CALL, k[7:0], 8'h00, 32'h0000_0200 + k, 1'b1);
            `CHK("call", exp_c, pc_load_r)
            `CHK("level", {3'h0, exp_c}, stack_level_r)
            if (exp_c) begin
                `CHK("pc_val", 32'h0000_0200 + k, pc_load_value_r)
                send(`OP_SUB_RETURN, 8'h00, 8'h00, 32'h0000_0000, 1'b1);
                `CHK("ret_pc", 32'h0000_0100 + k, pc_load_value_r)
                `CHK("level", 4'h0, stack_level_r)
            end
        end
        // nine true calls: the ninth finds the stack full
        for (k = 0; k < 9; k++) begin
            @(posedge clk_sys);
            cond_flags <= 8'h40;
            pc_current <= 32'h0000_0300 + k;
            send(`OP_COND_CALL, 8'h02, 8'h00, 32'h0000_0400 + k, 1'b1);
            `CHK("call", k < 8, pc_load_r)
            `CHK("level", 4'(k < 8 ? k + 1 : 8), stack_level_r)
        end
        send(`OP_SUB_RETURN, 8'h00, 8'h00, 32'h0000_0000, 1'b1);
        `CHK("ret_pc", 32'h0000_0307, pc_load_value_r)
        send(`OP_RESTART, 8'h00, 8'h00, 32'h0000_000A, 1'b1);
        `CHK("clear", 1'b1, regs_clear_r)
        `CHK("pc_load", 1'b1, pc_load_r)
        `CHK("pc_val", 32'h0000_000A, pc_load_value_r)
        `CHK("level", 4'h0, stack_level_r)
        // each target mode, then halt, spin left, spin right abort it
        for (k = 0; k < 3; k++) begin
            @(posedge clk_sys);
            accu <= 32'h0000_1000 + k;
            send(`OP_MOVE_ACCU, k[7:0], 8'h07, 32'h0000_0000, 1'b0);
            `CHK("start", 1'b1, move_start_r)
            `CHK("target", 32'h0000_1000 + k, move_req_r.target)
            `CHK("mode", k[1:0], move_req_r.mode)
            `CHK("point", 8'h07, move_req_r.point_index)
            `CHK("status", `STATUS_OK, reply_status_r)
            `CHK("reply_op", `OP_MOVE_ACCU, reply_opcode_r)
            `CHK("reply_valid", 1'b1, reply_valid_r)
            send(k == 0 ? `OP_MOTOR_HALT : k == 1 ? `OP_SPIN_LEFT :
                `OP_SPIN_RIGHT, 8'h00, 8'h00, 32'h0000_0000, 1'b0);
            `CHK("abort", 1'b1, move_abort_r)
        end
        send(`OP_MOTOR_HALT, 8'h00, 8'h00, 32'h0000_0000, 1'b0);
        `CHK("abort", 1'b0, move_abort_r)
        send(`OP_MOVE_ACCU, 8'h03, 8'h00, 32'h0000_0000, 1'b0);
        `CHK("start", 1'b0, move_start_r)
        `CHK("status", `STATUS_OK, reply_status_r)
        // with the clock enable low a move command is not taken
        @(posedge clk_sys);
        clk_en <= 1'b0;
        send(`OP_MOVE_ACCU, 8'h00, 8'h00, 32'h0000_0000, 1'b0);
        `CHK("start", 1'b0, move_start_r)
        `CHK("reply_valid", 1'b0, reply_valid_r)
        @(posedge clk_sys);
        clk_en <= 1'b1;
        final_report();
    end
endmodule : motion_program_flow_interpreter_bench
